/* hw/core_interrupt_and_timer_option.sv */
// core interrupt control plus timer-zero / watchdog prescaler options.
// assumes all pin inputs are synchronous to clock, the timer-zero
// counter and watchdog counter live outside and consume the tick
// outputs, and the timer reports its overflow as a one-cycle pulse.
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`include "core_int_defs.svh"

module core_interrupt_and_timer_option
  import core_int_pkg::*;
(
  input  wire logic       clock,               // instruction clock
  input  wire logic       rst,                 // sync reset, high
  input  wire logic [8:0] regAddr,             // register address
  input  wire logic [7:0] regWdata,            // write data
  input  wire logic       regWr,               // write strobe
  input  wire logic       regRd,               // read strobe
  output logic      [7:0] regRdata,            // read data, next cycle
  input  wire logic       extIntPin,           // external interrupt pin
  input  wire logic [3:0] upperPortPins,       // port pins 7..4
  input  wire logic [7:0] portLatch,           // second port latch
  input  wire logic       timerZeroExtClkPin,  // timer zero ext clock
  input  wire logic       timerZeroOvf,        // timer overflow pulse
  input  wire logic       watchdogOscTick,     // watchdog osc pulse
  input  wire logic       periphIntReq,        // any enabled periph flag
  output logic      [7:0] pullupEn,            // per-pin pull-up enable
  output logic            timerZeroInc,        // timer increment pulse
  output logic            watchdogInc,         // watchdog incr pulse
  output logic            coreIntReq,          // request to the core
  output logic            irq                  // masked event interrupt
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg8_t                  optionCfg_ff;
  reg8_t                  intCtrl_ff;
  logic [`EVT_WIDTH-1:0]  evtStatus_ff;
  logic [`EVT_WIDTH-1:0]  evtMask_ff;
  logic [7:0]             rdata_ff;
  logic                   extPinPrev_ff;
  logic [3:0]             portPrev_ff;
  logic                   t0ClkPrev_ff;
  logic [7:0]             prescCnt_ff;
  presc_owner_e           prescOwnerPrev_ff;
  logic [7:0]             pullup_ff;
  logic                   t0Inc_ff;
  logic                   wdInc_ff;
  logic                   coreReq_ff;
  logic                   irq_ff;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic selOption = (regAddr == `ADDR_TIMER_PRESCALE_CONFIG) ||
                         (regAddr == `ADDR_TIMER_PRESCALE_CONFIG_M);
  wire logic selIntCtrl = (regAddr == `ADDR_CORE_INTERRUPT_CONTROL) ||
                          (regAddr == `ADDR_CORE_INTERRUPT_CONTROL_M);
  wire logic selStatus = (regAddr == `ADDR_EVENT_STATUS);
  wire logic selMask   = (regAddr == `ADDR_EVENT_MASK);

  wire logic wrOption  = regWr & selOption;
  wire logic wrIntCtrl = regWr & selIntCtrl;
  wire logic wrMask    = regWr & selMask;
  wire logic rdStatus  = regRd & selStatus;

  // unmapped addresses read as zero
  wire logic [7:0] nxt_rdata =
      selOption  ? optionCfg_ff :
      selIntCtrl ? intCtrl_ff :
      selStatus  ? {5'h00, evtStatus_ff} :
      selMask    ? {5'h00, evtMask_ff} : 8'h00;

  // ----------------------------------------------------------------
  // option fields
  // ----------------------------------------------------------------
  wire logic       pullupDisableN  = optionCfg_ff[`BIT_PULLUP_DISABLE_N];
  wire logic       extIntEdgeSel   = optionCfg_ff[`BIT_EXT_INT_EDGE_SEL];
  wire logic       timerZeroClkSrc = optionCfg_ff[`BIT_TIMER_ZERO_CLK_SRC];
  wire logic       timerZeroSrcEdge= optionCfg_ff[`BIT_TIMER_ZERO_SRC_EDGE];
  wire logic       prescalerAssign = optionCfg_ff[`BIT_PRESCALER_ASSIGN];
  wire logic [2:0] prescaleRate    =
      optionCfg_ff[`MSB_PRESCALE_RATE:`LSB_PRESCALE_RATE];

  // ----------------------------------------------------------------
  // interrupt control fields
  // ----------------------------------------------------------------
  wire logic globalIntEn       = intCtrl_ff[`BIT_GLOBAL_INT_EN];
  wire logic periphIntEn       = intCtrl_ff[`BIT_PERIPH_INT_EN];
  wire logic timerZeroOvfIntEn = intCtrl_ff[`BIT_TIMER_ZERO_OVF_EN];
  wire logic extPinIntEn       = intCtrl_ff[`BIT_EXT_PIN_INT_EN];
  wire logic portChangeIntEn   = intCtrl_ff[`BIT_PORT_CHANGE_INT_EN];
  wire logic timerZeroOvfFlag  = intCtrl_ff[`BIT_TIMER_ZERO_OVF_FLAG];
  wire logic extPinIntFlag     = intCtrl_ff[`BIT_EXT_PIN_INT_FLAG];
  wire logic portChangeFlag    = intCtrl_ff[`BIT_PORT_CHANGE_FLAG];

  // ----------------------------------------------------------------
  // pull-ups
  // ----------------------------------------------------------------
  wire logic [7:0] nxt_pullup =
      pullupDisableN ? 8'h00 : portLatch;

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  wire logic extRise = extIntPin & ~extPinPrev_ff;
  wire logic extFall = ~extIntPin & extPinPrev_ff;
  wire logic extPinEvt = extIntEdgeSel ? extRise : extFall;
  // compares against last sample; a change that reverts within one
  // cycle of the clock is not seen
  wire logic portChangeEvt = |(upperPortPins ^ portPrev_ff);

  // ----------------------------------------------------------------
  // timer zero source and shared prescaler
  // ----------------------------------------------------------------
  wire logic t0Rise = timerZeroExtClkPin & ~t0ClkPrev_ff;
  wire logic t0Fall = ~timerZeroExtClkPin & t0ClkPrev_ff;
  wire logic t0ExtEdge = timerZeroSrcEdge ? t0Fall : t0Rise;
  wire logic t0SrcTick = timerZeroClkSrc ? t0ExtEdge : 1'b1;

  wire presc_owner_e prescOwner =
      prescalerAssign ? PRESC_WATCHDOG : PRESC_TIMER_ZERO;
  wire logic prescIn = (prescOwner == PRESC_WATCHDOG) ?
                       watchdogOscTick : t0SrcTick;
  // watchdog gets half the timer ratio for the same code
  wire logic [3:0] prescShift = (prescOwner == PRESC_WATCHDOG) ?
      {1'b0, prescaleRate} : {1'b0, prescaleRate} + 4'h1;
  wire logic [8:0] prescRatio = 9'h001 << prescShift;
  wire logic [8:0] prescLimit = prescRatio - 9'h001;
  wire logic prescWrap = prescIn && (prescCnt_ff == prescLimit[7:0]);
  // counter restarts when ownership changes so neither sees a short
  // first period inherited from the other
  wire logic ownerSwap = (prescOwner != prescOwnerPrev_ff);
  wire logic [7:0] nxt_prescCnt =
      ownerSwap ? 8'h00 :
      prescWrap ? 8'h00 :
      prescIn   ? prescCnt_ff + 8'h01 : prescCnt_ff;

  wire logic nxt_t0Inc = (prescOwner == PRESC_TIMER_ZERO) ?
      (prescWrap & ~ownerSwap) : t0SrcTick;
  wire logic nxt_wdInc = (prescOwner == PRESC_WATCHDOG) ?
      (prescWrap & ~ownerSwap) : watchdogOscTick;

  // ----------------------------------------------------------------
  // interrupt control register: set wins over software clear
  // ----------------------------------------------------------------
  wire logic [2:0] hwSet = {timerZeroOvf, extPinEvt, portChangeEvt};
  wire logic [2:0] swFlags = wrIntCtrl ? regWdata[2:0] : intCtrl_ff[2:0];
  wire logic [2:0] nxt_flags = swFlags | hwSet;
  wire logic [4:0] nxt_enables =
      wrIntCtrl ? regWdata[7:3] : intCtrl_ff[7:3];
  wire reg8_t nxt_intCtrl = {nxt_enables, nxt_flags};

  // ----------------------------------------------------------------
  // core request
  // ----------------------------------------------------------------
  wire logic coreSrcReq =
      (timerZeroOvfIntEn & timerZeroOvfFlag) |
      (extPinIntEn & extPinIntFlag) |
      (portChangeIntEn & portChangeFlag);
  wire logic periphReq = periphIntEn & periphIntReq;
  wire logic nxt_coreReq = globalIntEn & (coreSrcReq | periphReq);

  // ----------------------------------------------------------------
  // event status / mask, read clears, set wins
  // ----------------------------------------------------------------
  wire logic [`EVT_WIDTH-1:0] evtSet = hwSet;
  wire logic [`EVT_WIDTH-1:0] nxt_evtStatus =
      (rdStatus ? {`EVT_WIDTH{1'b0}} : evtStatus_ff) | evtSet;
  wire logic [`EVT_WIDTH-1:0] nxt_evtMask =
      wrMask ? regWdata[`EVT_WIDTH-1:0] : evtMask_ff;
  wire logic nxt_irq = |(nxt_evtStatus & nxt_evtMask);

  // ----------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      optionCfg_ff <= `RST_TIMER_PRESCALE_CONFIG;
    end else if (wrOption) begin
      optionCfg_ff <= regWdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      intCtrl_ff <= `RST_CORE_INTERRUPT_CTRL;
    end else begin
      intCtrl_ff <= nxt_intCtrl;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      evtStatus_ff <= {`EVT_WIDTH{1'b0}};
    end else begin
      evtStatus_ff <= nxt_evtStatus;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      evtMask_ff <= `RST_EVENT_MASK;
    end else begin
      evtMask_ff <= nxt_evtMask;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= regRd ? nxt_rdata : 8'h00;
    end
  end

  // pins sampled once; reset loads zero as the reference, so a pin
  // already high at reset release raises an edge on the next cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      extPinPrev_ff <= 1'b0;
      portPrev_ff   <= 4'h0;
      t0ClkPrev_ff  <= 1'b0;
    end else begin
      extPinPrev_ff <= extIntPin;
      portPrev_ff   <= upperPortPins;
      t0ClkPrev_ff  <= timerZeroExtClkPin;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prescCnt_ff <= 8'h00;
    end else begin
      prescCnt_ff <= nxt_prescCnt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prescOwnerPrev_ff <= PRESC_WATCHDOG;
    end else begin
      prescOwnerPrev_ff <= prescOwner;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      t0Inc_ff <= 1'b0;
    end else begin
      t0Inc_ff <= nxt_t0Inc;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wdInc_ff <= 1'b0;
    end else begin
      wdInc_ff <= nxt_wdInc;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pullup_ff <= 8'h00;
    end else begin
      pullup_ff <= nxt_pullup;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      coreReq_ff <= 1'b0;
    end else begin
      coreReq_ff <= nxt_coreReq;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdata     = rdata_ff;
  assign pullupEn     = pullup_ff;
  assign timerZeroInc = t0Inc_ff;
  assign watchdogInc  = wdInc_ff;
  assign coreIntReq   = coreReq_ff;
  assign irq          = irq_ff;

endmodule

/* hw/core_int_defs.svh */
// register offsets, field positions and reset values
// for the core interrupt and timer option block.
// assumes a 9-bit register address space on a plain strobe port.
`ifndef CORE_INT_DEFS_SVH
`define CORE_INT_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_TIMER_PRESCALE_CONFIG    9'h081
`define ADDR_TIMER_PRESCALE_CONFIG_M  9'h181
`define ADDR_CORE_INTERRUPT_CONTROL   9'h10b
`define ADDR_CORE_INTERRUPT_CONTROL_M 9'h18b
`define ADDR_EVENT_STATUS             9'h1f0
`define ADDR_EVENT_MASK               9'h1f1

// ----------------------------------------------------------------
// timer_prescale_config fields
// ----------------------------------------------------------------
`define BIT_PULLUP_DISABLE_N     7
`define BIT_EXT_INT_EDGE_SEL     6
`define BIT_TIMER_ZERO_CLK_SRC   5
`define BIT_TIMER_ZERO_SRC_EDGE  4
`define BIT_PRESCALER_ASSIGN     3
`define MSB_PRESCALE_RATE        2
`define LSB_PRESCALE_RATE        0

// ----------------------------------------------------------------
// core_interrupt_control fields
// ----------------------------------------------------------------
`define BIT_GLOBAL_INT_EN        7
`define BIT_PERIPH_INT_EN        6
`define BIT_TIMER_ZERO_OVF_EN    5
`define BIT_EXT_PIN_INT_EN       4
`define BIT_PORT_CHANGE_INT_EN   3
`define BIT_TIMER_ZERO_OVF_FLAG  2
`define BIT_EXT_PIN_INT_FLAG     1
`define BIT_PORT_CHANGE_FLAG     0

// ----------------------------------------------------------------
// event status / mask fields
// ----------------------------------------------------------------
`define EVT_PORT_CHANGE          0
`define EVT_EXT_PIN              1
`define EVT_TIMER_ZERO_OVF       2
`define EVT_WIDTH                3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_TIMER_PRESCALE_CONFIG 8'hff
`define RST_CORE_INTERRUPT_CTRL   8'h00
`define RST_EVENT_MASK            3'h0

`endif

/* hw/core_int_pkg.sv */
// types shared by the core interrupt and timer option block.
// assumes core_int_defs.svh supplies the numeric constants.
package core_int_pkg;

  typedef logic [7:0] reg8_t;

  // which counter owns the shared prescaler
  typedef enum logic {
    PRESC_TIMER_ZERO,
    PRESC_WATCHDOG
  } presc_owner_e;

endpackage

/* verif/core_interrupt_and_timer_option_assertions.sv */
// port checker for the core interrupt and timer option block.
// assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`include "core_int_defs.svh"
module core_int_checker (
  input wire logic       clock,         // clock
  input wire logic       rst,           // sync reset
  input wire logic [8:0] regAddr,       // address
  input wire logic [7:0] regWdata,      // write data
  input wire logic       regWr,         // write strobe
  input wire logic       extIntPin,     // ext pin
  input wire logic [3:0] upperPortPins, // port pins
  input wire logic [7:0] portLatch,     // latch
  input wire logic       timerZeroOvf,  // overflow
  input wire logic       watchdogOscTick, // wd tick
  input wire logic [7:0] pullupEn,      // pull-ups
  input wire logic       timerZeroInc,  // timer inc
  input wire logic       watchdogInc,   // wd inc
  input wire logic       coreIntReq,    // core request
  input wire logic       irq            // event irq
);
  // ----------------------------------------------------------------
  // shadow of software writes
  // ----------------------------------------------------------------
  // flag bits are never checked: only enables, options and the event mask matter here
  logic [7:0] optH_ff, ctrlH_ff;
  logic [2:0] maskH_ff;
  wire optW = regWr && (regAddr == `ADDR_TIMER_PRESCALE_CONFIG ||
                        regAddr == `ADDR_TIMER_PRESCALE_CONFIG_M);
  wire ctrlW = regWr && (regAddr == `ADDR_CORE_INTERRUPT_CONTROL ||
                         regAddr == `ADDR_CORE_INTERRUPT_CONTROL_M);
  wire maskW = regWr && regAddr == `ADDR_EVENT_MASK;
  always_ff @(posedge clock) begin
    if (rst) begin
      optH_ff <= `RST_TIMER_PRESCALE_CONFIG;
      ctrlH_ff <= `RST_CORE_INTERRUPT_CTRL;
      maskH_ff <= `RST_EVENT_MASK;
    end else begin
      if (optW) optH_ff <= regWdata;
      if (ctrlW) ctrlH_ff <= regWdata;
      if (maskW) maskH_ff <= regWdata[2:0];
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_PULLUP_OFF: assert property (
    optW && regWdata[7] |-> ##2 pullupEn == 8'h00)
    else $error("pull-ups not off");
  AST_PULLUP_FOLLOW: assert property (
    optW && !regWdata[7] |-> ##2 pullupEn == $past(portLatch))
    else $error("pull-ups not following latch");
  AST_GLOBAL_OFF: assert property (
    ctrlW && !regWdata[7] |-> ##2 !coreIntReq)
    else $error("request with global enable off");
  AST_PERIPH_BLOCK: assert property (
    ctrlH_ff[7:3] == 5'h10 |-> ##1 !coreIntReq)
    else $error("peripheral request not blocked");
  AST_TMR_OVF: assert property (
    !ctrlW && ctrlH_ff[7] && ctrlH_ff[5] && timerZeroOvf |-> ##2 coreIntReq)
    else $error("overflow gave no request");
  AST_PORT_CHG: assert property (
    !ctrlW && ctrlH_ff[7] && ctrlH_ff[3] &&
    upperPortPins != $past(upperPortPins) |-> ##2 coreIntReq)
    else $error("port change gave no request");
  AST_EXT_RISE: assert property (
    maskH_ff[1] && optH_ff[6] && $rose(extIntPin) |-> ##1 irq)
    else $error("rising edge missed");
  AST_EXT_FALL: assert property (
    maskH_ff[1] && !optH_ff[6] && $fell(extIntPin) |-> ##1 irq)
    else $error("falling edge missed");
  AST_TMR_UNDIV: assert property (
    optH_ff[3] && !optH_ff[5] |-> ##1 timerZeroInc)
    else $error("timer not undivided");
  AST_WDOG_UNDIV: assert property (
    !optH_ff[3] && watchdogOscTick |-> ##1 watchdogInc)
    else $error("watchdog not undivided");
  AST_TMR_DIV2: assert property (
    $stable(optH_ff) && optH_ff[5:0] == 6'h00 && timerZeroInc
    |-> ##1 !timerZeroInc)
    else $error("timer divide by two broken");
endmodule

/* verif/timer_zero_model.sv */
// far-side timer-zero counter, eight bits, wraps into a pulse.
// assumes increments arrive as one-cycle pulses on the same clock.
`timescale 1ns/10ps
module timer_zero_model (
  input  wire logic clock,        // instruction clock
  input  wire logic rst,          // sync reset, high
  input  wire logic timerZeroInc, // increment pulse
  output logic      timerZeroOvf  // wrap pulse
);
  logic [7:0] count_ff;
  always_ff @(posedge clock) begin
    if (rst) begin
      count_ff <= 8'h00;
      timerZeroOvf <= 1'b0;
    end else begin
      if (timerZeroInc) count_ff <= count_ff + 8'h01;
      timerZeroOvf <= timerZeroInc && count_ff == 8'hff;
    end
  end
endmodule

/* verif/core_interrupt_and_timer_option_bench.sv */
// self-checking bench for the core interrupt and timer option block.
// assumes the timer-zero model on the far side and the bound checker.
`timescale 1ns/10ps
`include "core_int_defs.svh"
bind core_interrupt_and_timer_option core_int_checker chk (.clock,
  .rst, .regAddr, .regWdata, .regWr, .extIntPin, .upperPortPins,
  .portLatch, .timerZeroOvf, .watchdogOscTick, .pullupEn,
  .timerZeroInc, .watchdogInc, .coreIntReq, .irq);
module core_interrupt_and_timer_option_bench;
  logic [8:0]  regAddr;
  logic [7:0]  regWdata, regRdata, portLatch, pullupEn;
  logic [3:0]  upperPortPins;
  logic        clock, rst, regWr, regRd, extIntPin, timerZeroExtClkPin;
  logic        timerZeroOvf, watchdogOscTick, periphIntReq;
  logic        timerZeroInc, watchdogInc, coreIntReq, irq;
  logic [15:0] tCnt, wCnt, rdv;
  int          numErrors, samplesChecked, cycles;
  core_interrupt_and_timer_option dut (.clock, .rst, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .extIntPin, .upperPortPins,
    .portLatch, .timerZeroExtClkPin, .timerZeroOvf, .watchdogOscTick,
    .periphIntReq, .pullupEn, .timerZeroInc, .watchdogInc, .coreIntReq,
    .irq);
  timer_zero_model far (.clock, .rst, .timerZeroInc, .timerZeroOvf);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // bus and check helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, g);
    samplesChecked++;
    if (g !== e) begin
      numErrors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    rdv = {8'h00, regRdata};
  endtask
  task automatic wo(input logic [7:0] d);
    wr(`ADDR_TIMER_PRESCALE_CONFIG, d);
  endtask
  task automatic wc(input logic [7:0] d);
    wr(`ADDR_CORE_INTERRUPT_CONTROL, d);
  endtask
  task automatic w3();
    repeat (3) @(negedge clock);
  endtask
  task automatic cnt(input logic [15:0] n);
    tCnt = 16'h0000;
    wCnt = 16'h0000;
    repeat (n) begin
      @(negedge clock);
      tCnt = tCnt + {15'h0000, timerZeroInc};
      wCnt = wCnt + {15'h0000, watchdogInc};
    end
  endtask
  task automatic tgl();
    logic [15:0] s;
    s = 16'h0000;
    repeat (3) begin
      @(posedge clock);
      timerZeroExtClkPin <= ~timerZeroExtClkPin;
      cnt(16'h0004);
      s = s + tCnt;
    end
    tCnt = s;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    rd(`ADDR_TIMER_PRESCALE_CONFIG_M);
    chk("option", 16'h00ff, rdv);
    rd(`ADDR_CORE_INTERRUPT_CONTROL_M);
    chk("control", 16'h0000, rdv);
    rd(9'h000);
    chk("unmapped", 16'h0000, rdv);
    chk("pullups", 16'h0000, {8'h00, pullupEn});
    $display("reset test done");
  endtask
  task automatic test_pullups();
    wo(8'h48);
    w3();
    chk("pullOn", 16'h00a5, {8'h00, pullupEn});
    wo(8'hc8);
    w3();
    chk("pullOff", 16'h0000, {8'h00, pullupEn});
    wo(8'h48);
    $display("pull-up test done");
  endtask
  task automatic test_timer_ovf();
    wc(8'h00);
    wc(8'ha0);
    repeat (300) begin
      @(negedge clock);
      if (coreIntReq === 1'b1) break;
    end
    chk("ovfReq", 16'h0001, {15'h0000, coreIntReq});
    chk("maskedIrq", 16'h0000, {15'h0000, irq});
    wc(8'h24);
    w3();
    chk("gieOff", 16'h0000, {15'h0000, coreIntReq});
    rd(`ADDR_CORE_INTERRUPT_CONTROL);
    chk("flagKept", 16'h0024, rdv);
    wc(8'h00);
    wo(8'h47);
    $display("overflow test done");
  endtask
  task automatic ext(input logic v, input logic [15:0] e);
    @(posedge clock);
    extIntPin <= v;
    w3();
    chk("extIrq", e, {15'h0000, irq});
    rd(`ADDR_EVENT_STATUS);
  endtask
  task automatic test_ext_pin();
    wr(`ADDR_EVENT_MASK, 8'h02);
    rd(`ADDR_EVENT_STATUS);
    ext(1'b1, 16'h0001);
    chk("status", 16'h0002, rdv & 16'h0002);
    chk("cleared", 16'h0000, {15'h0000, irq});
    ext(1'b0, 16'h0000);
    wo(8'h07);
    ext(1'b1, 16'h0000);
    ext(1'b0, 16'h0001);
    rd(`ADDR_CORE_INTERRUPT_CONTROL);
    chk("extFlag", 16'h0002, rdv & 16'h0002);
    $display("external pin test done");
  endtask
  task automatic test_port_periph();
    wc(8'h08);
    @(posedge clock);
    upperPortPins <= 4'h9;
    w3();
    chk("noGie", 16'h0000, {15'h0000, coreIntReq});
    rd(`ADDR_CORE_INTERRUPT_CONTROL);
    chk("portFlag", 16'h0009, rdv);
    wc(8'h88);
    @(posedge clock);
    upperPortPins <= 4'h1;
    w3();
    chk("portReq", 16'h0001, {15'h0000, coreIntReq});
    wc(8'h80);
    periphIntReq <= 1'b1;
    w3();
    chk("peieOff", 16'h0000, {15'h0000, coreIntReq});
    wc(8'hc0);
    w3();
    chk("peieOn", 16'h0001, {15'h0000, coreIntReq});
    periphIntReq <= 1'b0;
    wc(8'h00);
    $display("port and peripheral test done");
  endtask
  task automatic test_prescale();
    logic [15:0] win;
    // owner swap clears a count left above the rate-0 limit
    wo(8'h08);
    for (int n = 0; n < 8; n++) begin
      win = 16'h0008 << n;
      wo(8'(n));
      w3();
      cnt(win);
      chk("tmrDiv", 16'h0004, tCnt);
      chk("wdUndiv", win, wCnt);
      wo(8'(n) | 8'h08);
      w3();
      cnt(win);
      chk("tmrUndiv", win, tCnt);
      chk("wdDiv", 16'h0008, wCnt);
    end
    wo(8'h28);
    tgl();
    chk("extRise", 16'h0002, tCnt);
    wo(8'h38);
    tgl();
    chk("extFall", 16'h0002, tCnt);
    $display("prescaler test done");
  endtask
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ceiling well above the roughly 4600 cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      tally_and_finish();
    end
  end
  initial begin
    rst = 1'b1;
    regAddr = 9'h000;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    extIntPin = 1'b0;
    upperPortPins = 4'h0;
    portLatch = 8'ha5;
    timerZeroExtClkPin = 1'b0;
    watchdogOscTick = 1'b1;
    periphIntReq = 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    test_reset();
    test_pullups();
    test_timer_ovf();
    test_ext_pin();
    test_port_periph();
    test_prescale();
    tally_and_finish();
  end
endmodule
